// file: common/brc_pkg.sv
// constants and types of the burst and restart control block
package brc_pkg;
   // =====================================
   // timing
   localparam int CLK_PERIOD_NS  = 40;
   localparam int DET_WINDOW_NS  = 1_000_000;
   localparam int BLANK_TIME_NS  = 20_000_000;
   localparam int DET_CYCLES     = DET_WINDOW_NS / CLK_PERIOD_NS;
   localparam int BLANK_CYCLES   = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // =====================================
   // level decode boundaries (cycle counts)
   localparam int CNT_BOUND_142   = 16;
   localparam int CNT_BOUND_127   = 64;
   localparam int CNT_BOUND_NEVER = 160;
   localparam int DET_CNT_W       = 8;
   localparam int RST_CNT_W       = 8;
   // =====================================
   // register map
   localparam logic [3:0]  REG_STATUS        = 4'h0;
   localparam logic [3:0]  REG_CTRL          = 4'h4;
   localparam logic [31:0] CTRL_RESET        = 32'h0000_0001;
   localparam int          CTRL_BURST_ALLOW  = 0;
   localparam int          ST_DET_DONE       = 0;
   localparam int          ST_LEVEL_LSB      = 1;
   localparam int          ST_BURST          = 3;
   localparam int          ST_BIAS           = 4;
   localparam int          ST_MODE_LSB       = 5;
   localparam int          ST_RCNT_LSB       = 8;
   // =====================================
   // types
   typedef enum logic [1:0] {
      LVL_160   = 2'b00,
      LVL_142   = 2'b01,
      LVL_127   = 2'b10,
      LVL_NEVER = 2'b11
   } brc_level_type;
   typedef enum logic [1:0] {
      DET_WAIT = 2'b00,
      DET_RUN  = 2'b01,
      DET_DONE = 2'b10
   } brc_det_type;
   typedef enum logic [1:0] {
      RST_NONE   = 2'b00,
      RST_NORMAL = 2'b01,
      RST_ODD    = 2'b10,
      RST_NOSW   = 2'b11
   } brc_mode_type;
endpackage : brc_pkg

// file: rtl/brc_control.sv
// burst entry level detection, active burst mode and auto-restart sequencing
`timescale 1ns/100ps
// Functional notes
// [R1] - level detection runs only in first 1ms after supply lockout releases at 17V
// [R2] - detection happens once; later restarts keep the first level
// [R3] - detection waits while external enable or brownout protection is active
// [R4] - 4.5V sets detect flipflop, closes discharge, counts; 0.5V resets and opens
// [R5] - at window end the count picks 1.60V, 1.42V, 1.27V or never
// [R6] - matching burst current limit 0.45V, 0.37V, 0.31V; never setting skips burst
// [R7] - blanking counter held at zero until feedback drops below entry threshold
// [R8] - burst entered only when 20ms blanking elapses with feedback still low
// [R9] - burst entry sets burst flag and switches internal bias off
// [R10] - above 3.5V in burst: bias on, pulses with reduced burst current limit
// [R11] - down at 3.2V in burst: bias off, pulses stop, flag stays set
// [R12] - above 4.0V in burst: leave burst, block burst limit, full limit again
// [R13] - odd-skip: odd cycles no detection, no switching; even cycles detect, soft start
// [R14] - odd-skip returns to normal only in even cycle with fault cleared
// [R15] - non-switching: no pulses any cycle; fault still checked in even cycles
// [R16] - non-switching resumes normal at even cycle once fault removed
// [R17] - overvoltage, overload, open loop odd-skip; undervoltage, opto normal; thermal, external non-switching
// [R18] - cycle count decoded into four levels by fixed design boundaries
// [R19] - restart cycle counter starts at one when a fault latches
module brc_control #(
   parameter int DET_CYC   = brc_pkg::DET_CYCLES,
   parameter int BLANK_CYC = brc_pkg::BLANK_CYCLES,
   parameter int BND_142   = brc_pkg::CNT_BOUND_142,
   parameter int BND_127   = brc_pkg::CNT_BOUND_127,
   parameter int BND_NEVER = brc_pkg::CNT_BOUND_NEVER
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // avalon-mm slave
   input  wire logic [3:0]           address,
   input  wire logic                 read,
   input  wire logic                 write,
   input  wire logic [31:0]          writedata,
   output logic [31:0]               readdata,
   output logic                      waitrequest,
   // supply and protection state
   input  wire logic                 supply_on,
   input  wire logic                 protect_hold,
   // feedback comparators
   input  wire logic                 fb_above_4v5,
   input  wire logic                 fb_below_0v5,
   input  wire logic                 fb_below_entry,
   input  wire logic                 fb_above_3v5,
   input  wire logic                 fb_below_3v2,
   input  wire logic                 fb_above_4v0,
   // fault flags
   input  wire logic                 flt_ovp1,
   input  wire logic                 flt_ovp2,
   input  wire logic                 flt_overload,
   input  wire logic                 flt_open_loop,
   input  wire logic                 flt_undervolt,
   input  wire logic                 flt_opto_short,
   input  wire logic                 flt_overtemp,
   input  wire logic                 flt_ext_enable,
   // control outputs
   output logic                      level_discharge_switch,
   output brc_pkg::brc_level_type    burst_entry_threshold,
   output logic                      level_valid,
   output logic                      burst_flag,
   output logic                      bias_on,
   output logic                      burst_limit_gate,
   output logic                      pulse_enable,
   output logic                      fault_detect_en,
   output brc_pkg::brc_mode_type     restart_mode,
   output logic [brc_pkg::RST_CNT_W-1:0] restart_count
);
   import brc_pkg::*;

   // =====================================
   // level detection
   brc_det_type                 det_state, next_det_state;
   logic [$clog2(DET_CYC+1)-1:0] det_timer, next_det_timer;
   logic [DET_CNT_W-1:0]        det_cnt, next_det_cnt;
   logic                        next_ff;
   brc_level_type               next_level;

   always_comb begin
      next_det_state = det_state;
      next_det_timer = det_timer;
      next_det_cnt   = det_cnt;
      next_ff        = level_discharge_switch;
      next_level     = burst_entry_threshold;
      unique case (det_state)
         DET_WAIT: begin
            if (supply_on && !protect_hold) begin // [R1] [R3]
               next_det_state = DET_RUN;
               next_det_timer = '0;
               next_det_cnt   = '0;
               next_ff        = 1'b0;
            end
         end
         DET_RUN: begin
            next_det_timer = det_timer + 1'b1;
            if (!level_discharge_switch && fb_above_4v5) begin // [R4]
               next_ff = 1'b1;
               if (det_cnt != '1) begin
                  next_det_cnt = det_cnt + 1'b1;
               end
            end else if (level_discharge_switch && fb_below_0v5) begin // [R4]
               next_ff = 1'b0;
            end
            if (det_timer == ($clog2(DET_CYC+1))'(DET_CYC - 1)) begin // [R1]
               next_det_state = DET_DONE;
               next_ff        = 1'b0;
               if (det_cnt >= DET_CNT_W'(BND_NEVER)) begin // [R5] [R18]
                  next_level = LVL_NEVER;
               end else if (det_cnt >= DET_CNT_W'(BND_127)) begin
                  next_level = LVL_127;
               end else if (det_cnt >= DET_CNT_W'(BND_142)) begin
                  next_level = LVL_142;
               end else begin
                  next_level = LVL_160;
               end
            end
         end
         DET_DONE: begin
            next_det_state = DET_DONE; // [R2]
         end
         default: begin
            next_det_state = DET_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         det_state              <= DET_WAIT;
         det_timer              <= '0;
         det_cnt                <= '0;
         level_discharge_switch <= 1'b0;
         burst_entry_threshold  <= LVL_NEVER;
      end else begin
         det_state              <= next_det_state;
         det_timer              <= next_det_timer;
         det_cnt                <= next_det_cnt;
         level_discharge_switch <= next_ff;
         burst_entry_threshold  <= next_level;
      end
   end

   assign level_valid = (det_state == DET_DONE);

   // =====================================
   // register bus
   logic [31:0] ctrl, next_ctrl;
   logic [31:0] next_readdata;
   logic        ack, next_ack;
   logic [31:0] status;

   always_comb begin
      status = '0;
      status[ST_DET_DONE]                = level_valid;
      status[ST_LEVEL_LSB +: 2]          = burst_entry_threshold;
      status[ST_BURST]                   = burst_flag;
      status[ST_BIAS]                    = bias_on;
      status[ST_MODE_LSB +: 2]           = restart_mode;
      status[ST_RCNT_LSB +: RST_CNT_W]   = restart_count;
   end

   always_comb begin
      next_ack      = (read || write) && !ack;
      next_ctrl     = ctrl;
      next_readdata = readdata;
      if (write && ack && address == REG_CTRL) begin
         next_ctrl = writedata & CTRL_RESET;
      end
      if (read && !ack) begin
         unique case (address)
            REG_STATUS: next_readdata = status;
            REG_CTRL:   next_readdata = ctrl;
            default:    next_readdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack      <= 1'b0;
         ctrl     <= CTRL_RESET;
         readdata <= '0;
      end else begin
         ack      <= next_ack;
         ctrl     <= next_ctrl;
         readdata <= next_readdata;
      end
   end

   assign waitrequest = (read || write) && !ack;

   // =====================================
   // active burst mode
   logic [$clog2(BLANK_CYC+1)-1:0] blank_cnt, next_blank_cnt;
   logic                           next_burst, next_bias;
   logic                           burst_ok;

   assign burst_ok = level_valid && burst_entry_threshold != LVL_NEVER // [R6]
                     && ctrl[CTRL_BURST_ALLOW] && restart_mode == RST_NONE && supply_on;

   always_comb begin
      next_blank_cnt = '0; // [R7]
      next_burst     = burst_flag;
      next_bias      = bias_on;
      if (!burst_ok) begin
         next_burst = 1'b0;
         next_bias  = 1'b1;
      end else if (!burst_flag) begin
         next_bias = 1'b1;
         if (fb_below_entry) begin // [R7]
            if (blank_cnt == ($clog2(BLANK_CYC+1))'(BLANK_CYC - 1)) begin // [R8]
               next_burst = 1'b1; // [R9]
               next_bias  = 1'b0;
            end else begin
               next_blank_cnt = blank_cnt + 1'b1;
            end
         end
      end else if (fb_above_4v0) begin // [R12]
         next_burst = 1'b0;
         next_bias  = 1'b1;
      end else if (!bias_on && fb_above_3v5) begin // [R10]
         next_bias = 1'b1;
      end else if (bias_on && fb_below_3v2) begin // [R11]
         next_bias = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         blank_cnt  <= '0;
         burst_flag <= 1'b0;
         bias_on    <= 1'b1;
      end else begin
         blank_cnt  <= next_blank_cnt;
         burst_flag <= next_burst;
         bias_on    <= next_bias;
      end
   end

   assign burst_limit_gate = burst_flag; // [R10] [R12]

   // =====================================
   // auto-restart sequencing
   brc_mode_type             next_mode;
   logic [RST_CNT_W-1:0]     next_rcnt;
   logic                     supply_q, next_supply_q;
   logic                     flt_odd, flt_norm, flt_nosw, flt_any;
   logic                     cycle_start, even_next;

   assign flt_odd  = flt_ovp1 || flt_ovp2 || flt_overload || flt_open_loop; // [R17]
   assign flt_norm = flt_undervolt || flt_opto_short;
   assign flt_nosw = flt_overtemp || flt_ext_enable;
   assign flt_any  = flt_odd || flt_norm || flt_nosw;
   assign cycle_start = supply_on && !supply_q;
   assign even_next   = !restart_count[0];

   always_comb begin
      next_mode     = restart_mode;
      next_rcnt     = restart_count;
      next_supply_q = supply_on;
      unique case (restart_mode)
         RST_NONE: begin
            if (supply_on && flt_any) begin
               next_rcnt = RST_CNT_W'(1); // [R19]
               if (flt_nosw) begin // [R17]
                  next_mode = RST_NOSW;
               end else if (flt_odd) begin
                  next_mode = RST_ODD;
               end else begin
                  next_mode = RST_NORMAL;
               end
            end
         end
         RST_NORMAL: begin
            if (cycle_start) begin
               next_rcnt = restart_count + 1'b1;
               if (!flt_any) begin
                  next_mode = RST_NONE;
               end
            end
         end
         RST_ODD, RST_NOSW: begin
            if (cycle_start) begin
               next_rcnt = restart_count + 1'b1;
               if (restart_count[0] && !flt_any) begin // [R14] [R16]
                  next_mode = RST_NONE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         restart_mode  <= RST_NONE;
         restart_count <= '0;
         supply_q      <= 1'b0;
      end else begin
         restart_mode  <= next_mode;
         restart_count <= next_rcnt;
         supply_q      <= next_supply_q;
      end
   end

   // =====================================
   // switching and detection gating
   always_comb begin
      pulse_enable    = 1'b0;
      fault_detect_en = 1'b0;
      unique case (restart_mode)
         RST_NONE: begin
            pulse_enable    = supply_on && bias_on;
            fault_detect_en = supply_on;
         end
         RST_NORMAL: begin
            pulse_enable    = supply_on;
            fault_detect_en = supply_on;
         end
         RST_ODD: begin
            pulse_enable    = supply_on && even_next; // [R13]
            fault_detect_en = supply_on && even_next; // [R13]
         end
         RST_NOSW: begin
            pulse_enable    = 1'b0; // [R15]
            fault_detect_en = supply_on && even_next; // [R15]
         end
      endcase
   end
endmodule : brc_control

// file: test/brc_control_sva.sv
// assertion checker for the burst and restart control block
`timescale 1ns/100ps
module brc_control_sva #(
   parameter int BLANK_CYC = brc_pkg::BLANK_CYCLES
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   // supply, comparators and faults
   input  wire logic                   supply_on,
   input  wire logic                   fb_above_4v5,
   input  wire logic                   fb_below_0v5,
   input  wire logic                   fb_below_entry,
   input  wire logic                   fb_above_3v5,
   input  wire logic                   fb_below_3v2,
   input  wire logic                   fb_above_4v0,
   input  wire logic                   flt_overtemp,
   input  wire logic                   flt_ext_enable,
   // control outputs
   input  wire logic                   level_discharge_switch,
   input  wire brc_pkg::brc_level_type burst_entry_threshold,
   input  wire logic                   level_valid,
   input  wire logic                   burst_flag,
   input  wire logic                   bias_on,
   input  wire logic                   burst_limit_gate,
   input  wire logic                   pulse_enable,
   input  wire logic                   fault_detect_en,
   input  wire brc_pkg::brc_mode_type  restart_mode,
   input  wire logic [7:0]             restart_count
);
   import brc_pkg::*;
   logic [31:0] low_run;
   logic [31:0] next_low_run;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // =====================================
   // run of cycles with feedback below entry
   always_comb begin
      next_low_run = fb_below_entry ? ((low_run == 32'hffff_ffff) ? low_run : low_run + 32'h0000_0001) : 32'h0000_0000;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         low_run <= 32'h0000_0000;
      end else begin
         low_run <= next_low_run;
      end
   end
   // =====================================
   // properties
   a_disch_set: assert property ($rose(level_discharge_switch) |-> $past(fb_above_4v5) && !level_valid)
      else $error("discharge closed without 4.5V event");
   a_disch_clear: assert property ($fell(level_discharge_switch) |-> $past(fb_below_0v5) || level_valid)
      else $error("discharge opened without 0.5V event");
   a_level_keep: assert property (level_valid |=> level_valid && $stable(burst_entry_threshold))
      else $error("level result changed after detection");
   a_burst_entry: assert property ($rose(burst_flag) |-> !bias_on && burst_entry_threshold != LVL_NEVER
      && low_run >= BLANK_CYC)
      else $error("burst entered too early or without bias off");
   a_wake_bias: assert property (burst_flag && fb_above_3v5 && !fb_above_4v0 |=> bias_on)
      else $error("bias not restored on wake");
   a_sleep_bias: assert property (burst_flag && fb_below_3v2 && !fb_above_4v0 |=> !bias_on && burst_flag)
      else $error("bias not cut on sleep");
   a_leave_burst: assert property (burst_flag && fb_above_4v0 |=> !burst_flag && bias_on && !burst_limit_gate)
      else $error("burst not left on load jump");
   a_limit_gate: assert property (burst_limit_gate == burst_flag)
      else $error("burst limit gate differs from burst flag");
   a_odd_quiet: assert property (restart_mode == RST_ODD && restart_count[0] |-> !pulse_enable && !fault_detect_en)
      else $error("odd cycle not quiet");
   a_even_detect: assert property (restart_mode == RST_ODD && !restart_count[0] && supply_on |-> fault_detect_en)
      else $error("even cycle without fault detection");
   a_nosw_quiet: assert property (restart_mode == RST_NOSW |-> !pulse_enable)
      else $error("pulses in non-switching restart");
   a_nosw_latch: assert property (restart_mode == RST_NONE && supply_on && (flt_overtemp || flt_ext_enable)
      |=> restart_mode == RST_NOSW && restart_count == 8'h01)
      else $error("thermal or external fault not latched");
endmodule : brc_control_sva
bind brc_control brc_control_sva #(.BLANK_CYC(BLANK_CYC)) brc_control_sva_i (
   .clk(clk), .rst_b(rst_b), .supply_on(supply_on), .fb_above_4v5(fb_above_4v5), .fb_below_0v5(fb_below_0v5),
   .fb_below_entry(fb_below_entry), .fb_above_3v5(fb_above_3v5), .fb_below_3v2(fb_below_3v2),
   .fb_above_4v0(fb_above_4v0), .flt_overtemp(flt_overtemp), .flt_ext_enable(flt_ext_enable),
   .level_discharge_switch(level_discharge_switch), .burst_entry_threshold(burst_entry_threshold),
   .level_valid(level_valid), .burst_flag(burst_flag), .bias_on(bias_on), .burst_limit_gate(burst_limit_gate),
   .pulse_enable(pulse_enable), .fault_detect_en(fault_detect_en), .restart_mode(restart_mode),
   .restart_count(restart_count));

// file: test/brc_front_model.sv
// behavioural analog front end: feedback capacitor and comparators
`timescale 1ns/100ps
module brc_front_model (
   // clock and control from the block
   input  wire logic                   clk,
   input  wire logic                   level_discharge_switch,
   input  wire logic                   level_valid,
   input  wire brc_pkg::brc_level_type burst_entry_threshold,
   // commanded charge rate and feedback level, millivolts
   input  wire logic [15:0]            charge_step,
   input  wire logic [15:0]            fb_mv,
   // comparator levels
   output logic                        fb_above_4v5,
   output logic                        fb_below_0v5,
   output logic                        fb_below_entry,
   output logic                        fb_above_3v5,
   output logic                        fb_below_3v2,
   output logic                        fb_above_4v0
);
   import brc_pkg::*;
   logic [15:0] cap_mv = 16'h0000;
   logic [15:0] v_mv;
   logic [15:0] entry_mv;
   // =====================================
   // capacitor charged toward 5V, dumped through the switch
   always @(posedge clk) begin
      if (level_discharge_switch) begin
         cap_mv <= (cap_mv > 16'h05dc) ? cap_mv - 16'h05dc : 16'h0000;
      end else if (cap_mv < 16'h1388) begin
         cap_mv <= cap_mv + charge_step;
      end
   end
   // =====================================
   // comparators
   always_comb begin
      case (burst_entry_threshold)
         LVL_160: entry_mv = 16'h0640;
         LVL_142: entry_mv = 16'h058c;
         LVL_127: entry_mv = 16'h04f6;
         default: entry_mv = 16'h0000;
      endcase
   end
   assign v_mv           = level_valid ? fb_mv : cap_mv;
   assign fb_above_4v5   = v_mv > 16'h1194;
   assign fb_below_0v5   = v_mv < 16'h01f4;
   assign fb_below_entry = v_mv < entry_mv;
   assign fb_above_3v5   = v_mv > 16'h0dac;
   assign fb_below_3v2   = v_mv < 16'h0c80;
   assign fb_above_4v0   = v_mv > 16'h0fa0;
endmodule : brc_front_model

// file: test/brc_control_test.sv
// self-checking testbench of the burst and restart control block
`timescale 1ns/100ps
`define BRC_CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
   $display("BAD at %0t got %h expected %h", $time, got, exp); end end
module brc_control_test;
   import brc_pkg::*;
   localparam logic [31:0] M_ALL = 32'hffff_ffff;
   localparam logic [31:0] M_RS  = 32'hffff_ffe7;
   localparam logic [31:0] M_NC  = 32'hffff_00e7;
   logic          clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, supply_on = 1'b1, protect_hold = 1'b1;
   logic [3:0]    address = 4'h0;
   logic [31:0]   writedata = 32'h0000_0000;
   logic [7:0]    flt = 8'h00;
   logic [15:0]   step = 16'h03e8, fb_mv = 16'h07d0;
   logic [31:0]   readdata;
   logic [33:0]   ev, em;
   logic          waitrequest, disch, lvl_valid, a45, b05, bent, a35, b32, a40, b, pe, fd;
   brc_level_type thr;
   int            bad_count = 0, checks_done = 0;
   logic [33:0]   exp_q[$], msk_q[$];
   logic [15:0]   steps [4] = '{16'h03e8, 16'h0014, 16'h0064, 16'h00c8};
   logic [1:0]    lvls [4]  = '{2'h3, 2'h0, 2'h1, 2'h2};
   logic [1:0]    modes [8] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h3, 2'h3};
   always #20 clk = ~clk;
   // =====================================
   // design and front end
   brc_control #(.DET_CYC(240), .BLANK_CYC(40), .BND_142(3), .BND_127(8), .BND_NEVER(16)) brc_control_i (
      .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .supply_on(supply_on), .protect_hold(protect_hold),
      .fb_above_4v5(a45), .fb_below_0v5(b05), .fb_below_entry(bent), .fb_above_3v5(a35), .fb_below_3v2(b32),
      .fb_above_4v0(a40), .flt_ovp1(flt[0]), .flt_ovp2(flt[1]), .flt_overload(flt[2]), .flt_open_loop(flt[3]),
      .flt_undervolt(flt[4]), .flt_opto_short(flt[5]), .flt_overtemp(flt[6]), .flt_ext_enable(flt[7]),
      .level_discharge_switch(disch), .burst_entry_threshold(thr), .level_valid(lvl_valid), .burst_flag(),
      .bias_on(), .burst_limit_gate(), .pulse_enable(pe), .fault_detect_en(fd), .restart_mode(), .restart_count());
   brc_front_model brc_front_model_i (
      .clk(clk), .level_discharge_switch(disch), .level_valid(lvl_valid), .burst_entry_threshold(thr),
      .charge_step(step), .fb_mv(fb_mv), .fb_above_4v5(a45), .fb_below_0v5(b05), .fb_below_entry(bent),
      .fb_above_3v5(a35), .fb_below_3v2(b32), .fb_above_4v0(a40));
   // =====================================
   // tasks
   task automatic stop_test();
      if (bad_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      address   <= adr;
      writedata <= dat;
      read      <= !wr;
      write     <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         bad_count++;
         stop_test();
      end
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rd(input logic [3:0] adr, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] g = 2'b00, input logic [1:0] gm = 2'b00);
      exp_q.push_back({g, e});
      msk_q.push_back({gm, m});
      bus(1'b0, adr, 32'h0000_0000);
   endtask : rd
   task automatic power_cycle();
      supply_on <= 1'b0;
      cyc(3);
      supply_on <= 1'b1;
      cyc(3);
   endtask : power_cycle
   function automatic logic [31:0] st(input logic dn, input logic [1:0] lv, input logic bu, input logic bi,
                                      input logic [1:0] md, input logic [7:0] cn);
      st = {16'h0000, cn, 1'b0, md, bi, bu, lv, dn};
   endfunction : st
   // =====================================
   // result watcher
   always @(posedge clk) begin
      if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0) begin
         ev = exp_q.pop_front();
         em = msk_q.pop_front();
         `BRC_CHECK({pe, fd, readdata} & em, ev & em)
      end
   end
   // =====================================
   // main sequence
   initial begin
      void'($urandom(38));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         step  <= steps[i];
         fb_mv <= 16'h07d0 + 16'($urandom_range(999));
         b = (lvls[i] != 2'h3);
         if (i == 0) begin
            cyc(300);
            rd(4'h0, st(1'b0, 2'h3, 1'b0, 1'b1, 2'h0, 8'h00), M_ALL);
            bus(1'b1, 4'h4, 32'hffff_fffe);
            bus(1'b1, 4'h0, 32'hffff_ffff);
            rd(4'h4, 32'h0000_0000, M_ALL);
            rd(4'hc, 32'h0000_0000, M_ALL);
            bus(1'b1, 4'h4, 32'h0000_0001);
            protect_hold <= 1'b0;
         end else begin
            rst_b <= 1'b0;
            cyc(4);
            rst_b <= 1'b1;
         end
         cyc(270);
         rd(4'h0, st(1'b1, lvls[i], 1'b0, 1'b1, 2'h0, 8'h00), M_ALL);
         fb_mv <= 16'h012c;
         cyc(30);
         fb_mv <= 16'h09c4;
         cyc(2);
         fb_mv <= 16'h012c;
         cyc(30);
         rd(4'h0, st(1'b1, lvls[i], 1'b0, 1'b1, 2'h0, 8'h00), M_ALL);
         cyc(20);
         rd(4'h0, st(1'b1, lvls[i], b, !b, 2'h0, 8'h00), M_ALL);
         fb_mv <= 16'h0e10;
         cyc(3);
         rd(4'h0, st(1'b1, lvls[i], b, 1'b1, 2'h0, 8'h00), M_ALL);
         fb_mv <= 16'h0c1c;
         cyc(3);
         rd(4'h0, st(1'b1, lvls[i], b, !b, 2'h0, 8'h00), M_ALL);
         fb_mv <= 16'h1004;
         cyc(3);
         rd(4'h0, st(1'b1, lvls[i], 1'b0, 1'b1, 2'h0, 8'h00), M_ALL);
      end
      for (int f = 0; f < 8; f++) begin
         flt <= 8'h01 << f;
         cyc(2);
         rd(4'h0, st(1'b1, 2'h2, 1'b0, 1'b0, modes[f], 8'h01), M_RS,
            {modes[f] == 2'h1, modes[f] == 2'h1}, 2'b11);
         power_cycle();
         rd(4'h0, st(1'b1, 2'h2, 1'b0, 1'b0, modes[f], 8'h02), M_RS,
            {modes[f] != 2'h3, 1'b1}, 2'b11);
         flt <= 8'h00;
         power_cycle();
         rd(4'h0, st(1'b1, 2'h2, 1'b0, 1'b0, (modes[f] == 2'h1) ? 2'h0 : modes[f], 8'h03),
            (modes[f] == 2'h1) ? M_NC : M_RS);
         power_cycle();
         rd(4'h0, st(1'b1, 2'h2, 1'b0, 1'b0, 2'h0, 8'h00), M_NC);
      end
      stop_test();
   end
endmodule : brc_control_test
